/* rtl/nac_pkg.sv */
// Purpose: constants for the nand address/busy sequencer host
// Assumes: 100 MHz clock
// Notes: times in their own units, counts derived
`default_nettype none
package nac_pkg;
  localparam int CLK_MHZ = 100;
  localparam int CLK_NS = 10;
  localparam int ADDR_TO_DATA_WAIT_NS = 100;
  localparam int ADDR_TO_DATA_WAIT_CYC = (ADDR_TO_DATA_WAIT_NS + CLK_NS - 1) / CLK_NS;
  localparam int STROBE_TO_BUSY_WINDOW_NS = 100;
  localparam int STROBE_TO_BUSY_WINDOW_CYC = (STROBE_TO_BUSY_WINDOW_NS + CLK_NS - 1) / CLK_NS;
  // fixed strobe phase lengths: low and high halves of a write cycle
  localparam int WE_LOW_NS = 20;
  localparam int WE_LOW_CYC = (WE_LOW_NS + CLK_NS - 1) / CLK_NS;
  localparam int WE_HIGH_NS = 20;
  localparam int WE_HIGH_CYC = (WE_HIGH_NS + CLK_NS - 1) / CLK_NS;
  // longest device busy periods, used as timeout
  localparam int FIRST_RESET_MS = 1;
  localparam int FIRST_RESET_CYC = FIRST_RESET_MS * 1000 * CLK_MHZ;
  localparam int RESET_BUSY_US = 5;
  localparam int READ_BUSY_US = 25;
  localparam int PROGRAM_BUSY_US = 600;
  localparam int ERASE_BUSY_MS = 3;
  localparam int ERASE_BUSY_CYC = ERASE_BUSY_MS * 1000 * CLK_MHZ;
  localparam int LOCKED_BUSY_US = 3;
  localparam int OTP_BUSY_US = 30;
  localparam int FEATURE_BUSY_US = 3;
  localparam int CACHE_PROG_BUSY_US = 600;
  localparam int CACHE_READ_BUSY_US = 25;
  localparam int LAST_PAGE_PROGRAM_TIME_US = 2 * PROGRAM_BUSY_US;
  localparam int MAX_PARTIAL_PROGRAMS = 4;
  localparam int TMR_W = 24;
  localparam int ADDR_CYCLES = 5;
  localparam logic [7:0] CMD_RESET = 8'hff;
  typedef enum logic [2:0] {
    NAC_IDLE = 3'b000,
    NAC_CMD = 3'b001,
    NAC_ADDR = 3'b011,
    NAC_WAITD = 3'b010,
    NAC_WB = 3'b110,
    NAC_BUSY = 3'b111
  } nac_state_e;
endpackage
`default_nettype wire

/* rtl/nac_addr_pack.sv */
// Purpose: pack column/page/block into five address bytes
// Assumes: 11-bit column, 6-bit page, 17-bit block
// Notes: upper data lines always low during addressing
`default_nettype none
module nac_addr_pack
  import nac_pkg::*;
(
  input wire logic [10:0] column,
  input wire logic [5:0] page,
  input wire logic [16:0] block,
  input wire logic [2:0] idx,
  output logic [15:0] addrWord,
  output logic colLegal
);
  always_comb
  begin
    addrWord = 16'h0000;
    unique case (idx)
      3'h0: addrWord[7:0] = column[7:0];
      3'h1: addrWord[2:0] = column[10:8];
      3'h2: addrWord[7:0] = {block[7:6], page};
      3'h3: addrWord[7:0] = block[15:8];
      3'h4: addrWord[0] = block[16];
      default: addrWord = 16'h0000;
    endcase
  end
  // high column half only reaches spare area
  assign colLegal = !(column[10] && (column[9:5] != 5'h00));
endmodule
`default_nettype wire

/* rtl/nac_host.sv */
// Purpose: host sequencer for command, address and busy wait
// Assumes: device pins synchronous to clk
// Notes: one request at a time; data phase left to the user
// How it works
// - five address bytes, column bytes first
// - page/block packed into bytes three to five
// - spare column needs bits 9:5 zero
// - upper data lines low while addressing
// - wait 100 ns before data input
// - no command within strobe-to-busy window
// - at most four partial programs to one page, count reset by programming another page
// - reset is the first command
`default_nettype none
module nac_host
  import nac_pkg::*;
#(
  parameter int FIRST_RESET_LIMIT = FIRST_RESET_CYC,
  parameter int ERASE_LIMIT = ERASE_BUSY_CYC,
  parameter int PROGRAM_LIMIT = PROGRAM_BUSY_US * CLK_MHZ,
  parameter int LAST_PAGE_LIMIT = LAST_PAGE_PROGRAM_TIME_US * CLK_MHZ
)
(
  input wire logic clk,
  input wire logic reset,
  input wire logic reqValid,
  output logic reqReady,
  input wire logic [7:0] reqCmd,
  input wire logic reqHasAddr,
  input wire logic reqWaitBusy,
  input wire logic [2:0] reqBusyKind,
  input wire logic reqLastCache,
  input wire logic [10:0] reqColumn,
  input wire logic [5:0] reqPage,
  input wire logic [16:0] reqBlock,
  output logic dataGo,
  output logic done,
  output logic timeout,
  output logic refused,
  output logic commandLatch,
  output logic addressLatch,
  output logic writeStrobeN,
  output logic read_strobe_n,
  output logic chipEnableN,
  output logic [15:0] ioOut,
  output logic ioOe,
  input wire logic readyBusyN
);
  typedef struct packed {
    nac_state_e st;
    logic [TMR_W-1:0] tmr;
    logic [TMR_W-1:0] limit;
    logic phase;
    logic [2:0] idx;
    logic didReset;
    logic firstDone;
    logic [2:0] partials;
    logic [22:0] lastPage;
    logic waitBusy;
    logic dataGo;
    logic done;
    logic timeout;
    logic refused;
    logic cle;
    logic ale;
    logic weN;
    logic ce;
    logic [15:0] io;
    logic oe;
  } nac_s;
  nac_s q_r, q_nxt;
  logic [15:0] addrWord;
  logic colLegal;
  logic strobeDone;
  logic [TMR_W-1:0] busyLimit;
  nac_addr_pack u_pack (
    .column(reqColumn),
    .page(reqPage),
    .block(reqBlock),
    .idx(q_r.idx),
    .addrWord(addrWord),
    .colLegal(colLegal)
  );
  assign strobeDone = q_r.phase && (q_r.tmr == TMR_W'(WE_HIGH_CYC - 1));
  always_comb
  begin
    busyLimit = TMR_W'(RESET_BUSY_US * CLK_MHZ);
    unique case (reqBusyKind)
      3'h0: busyLimit = TMR_W'(RESET_BUSY_US * CLK_MHZ);
      3'h1: busyLimit = TMR_W'(READ_BUSY_US * CLK_MHZ);
      3'h2: busyLimit = reqLastCache ? TMR_W'(LAST_PAGE_LIMIT)
                                     : TMR_W'(PROGRAM_LIMIT);
      3'h3: busyLimit = TMR_W'(ERASE_LIMIT);
      3'h4: busyLimit = TMR_W'(OTP_BUSY_US * CLK_MHZ);
      3'h5: busyLimit = TMR_W'(FEATURE_BUSY_US * CLK_MHZ);
      3'h6: busyLimit = reqLastCache ? TMR_W'(LAST_PAGE_LIMIT)
                                     : TMR_W'(CACHE_PROG_BUSY_US * CLK_MHZ);
      3'h7: busyLimit = TMR_W'(CACHE_READ_BUSY_US * CLK_MHZ);
    endcase
    // locked-block attempts end early, covered by the longer limits
    if (reqCmd == CMD_RESET && !q_r.firstDone)
    begin
      busyLimit = TMR_W'(FIRST_RESET_LIMIT);
    end
  end
  assign reqReady = (q_r.st == NAC_IDLE);
  always_comb
  begin
    q_nxt = q_r;
    q_nxt.dataGo = 1'b0;
    q_nxt.done = 1'b0;
    q_nxt.timeout = 1'b0;
    q_nxt.refused = 1'b0;
    unique case (q_r.st)
      NAC_IDLE:
      begin
        if (reqValid)
        begin
          // refuse anything before reset, bad spare column or too many partials
          if ((!q_r.didReset && reqCmd != CMD_RESET) ||
              (reqHasAddr && !colLegal) ||
              (reqBusyKind == 3'h2 && reqHasAddr &&
               {reqBlock, reqPage} == q_r.lastPage &&
               q_r.partials == 3'(MAX_PARTIAL_PROGRAMS)))
          begin
            q_nxt.refused = 1'b1;
          end
          else
          begin
            if (reqBusyKind == 3'h2 && reqHasAddr)
            begin
              q_nxt.partials = ({reqBlock, reqPage} == q_r.lastPage) ?
                               q_r.partials + 3'h1 : 3'h1;
              q_nxt.lastPage = {reqBlock, reqPage};
            end
            if (reqCmd == CMD_RESET)
            begin
              q_nxt.didReset = 1'b1;
            end
            q_nxt.st = NAC_CMD;
            q_nxt.limit = busyLimit;
            q_nxt.waitBusy = reqWaitBusy;
            q_nxt.tmr = '0;
            q_nxt.phase = 1'b0;
            q_nxt.idx = 3'h0;
            q_nxt.ce = 1'b1;
            q_nxt.cle = 1'b1;
            q_nxt.weN = 1'b0;
            q_nxt.io = {8'h00, reqCmd};
            q_nxt.oe = 1'b1;
          end
        end
      end
      NAC_CMD, NAC_ADDR:
      begin
        q_nxt.tmr = q_r.tmr + TMR_W'(1);
        if (!q_r.phase && q_r.tmr == TMR_W'(WE_LOW_CYC - 1))
        begin
          q_nxt.phase = 1'b1;
          q_nxt.weN = 1'b1;
          q_nxt.tmr = '0;
        end
        else if (strobeDone)
        begin
          q_nxt.tmr = '0;
          q_nxt.phase = 1'b0;
          if (q_r.st == NAC_CMD && reqHasAddr)
          begin
            q_nxt.st = NAC_ADDR;
            q_nxt.cle = 1'b0;
            q_nxt.ale = 1'b1;
            q_nxt.weN = 1'b0;
            q_nxt.io = addrWord;
            q_nxt.idx = 3'h1;
          end
          else if (q_r.st == NAC_ADDR && q_r.idx != 3'(ADDR_CYCLES))
          begin
            q_nxt.weN = 1'b0;
            q_nxt.io = addrWord;
            q_nxt.idx = q_r.idx + 3'h1;
          end
          else
          begin
            q_nxt.cle = 1'b0;
            q_nxt.ale = 1'b0;
            q_nxt.io = 16'h0000;
            q_nxt.oe = 1'b0;
            q_nxt.st = q_r.waitBusy ? NAC_WB : NAC_WAITD;
          end
        end
      end
      NAC_WAITD:
      begin
        // strobe high time already counts toward the wait
        q_nxt.tmr = q_r.tmr + TMR_W'(1);
        if (q_r.tmr >= TMR_W'(ADDR_TO_DATA_WAIT_CYC - WE_HIGH_CYC - 1))
        begin
          q_nxt.dataGo = 1'b1;
          q_nxt.done = 1'b1;
          q_nxt.ce = 1'b0;
          q_nxt.st = NAC_IDLE;
        end
      end
      NAC_WB:
      begin
        // ready may still read high here, so it is not looked at
        q_nxt.tmr = q_r.tmr + TMR_W'(1);
        if (q_r.tmr >= TMR_W'(STROBE_TO_BUSY_WINDOW_CYC - 1))
        begin
          q_nxt.tmr = '0;
          q_nxt.st = NAC_BUSY;
        end
      end
      NAC_BUSY:
      begin
        q_nxt.tmr = q_r.tmr + TMR_W'(1);
        if (readyBusyN)
        begin
          q_nxt.done = 1'b1;
          q_nxt.ce = 1'b0;
          q_nxt.st = NAC_IDLE;
          if (reqCmd == CMD_RESET)
          begin
            q_nxt.firstDone = 1'b1;
          end
        end
        else if (q_r.tmr >= q_r.limit)
        begin
          q_nxt.timeout = 1'b1;
          q_nxt.ce = 1'b0;
          q_nxt.st = NAC_IDLE;
        end
      end
      default: q_nxt.st = NAC_IDLE;
    endcase
  end
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      q_r <= '{st: NAC_IDLE, tmr: '0, limit: '0, phase: 1'b0, idx: 3'h0,
               didReset: 1'b0, firstDone: 1'b0, partials: 3'h0, lastPage: '0,
               waitBusy: 1'b0, dataGo: 1'b0, done: 1'b0, timeout: 1'b0,
               refused: 1'b0, cle: 1'b0, ale: 1'b0, weN: 1'b1, ce: 1'b0,
               io: 16'h0000, oe: 1'b0};
    end
    else
    begin
      q_r <= q_nxt;
    end
  end
  assign dataGo = q_r.dataGo;
  assign done = q_r.done;
  assign timeout = q_r.timeout;
  assign refused = q_r.refused;
  assign commandLatch = q_r.cle;
  assign addressLatch = q_r.ale;
  assign writeStrobeN = q_r.weN;
  assign read_strobe_n = 1'b1;
  assign chipEnableN = !q_r.ce;
  assign ioOut = q_r.io;
  assign ioOe = q_r.oe;
endmodule
`default_nettype wire

/* dv/nac_host_asserts.sv */
// Purpose: port-level timing checks for the host sequencer
// Assumes: one clock, reset synchronous and active high
// Notes: bound to the sequencer from the bench top
`default_nettype none
module nac_host_asserts (
  input wire logic clk,
  input wire logic reset,
  input wire logic reqValid,
  input wire logic reqReady,
  input wire logic [7:0] reqCmd,
  input wire logic reqHasAddr,
  input wire logic [10:0] reqColumn,
  input wire logic dataGo,
  input wire logic done,
  input wire logic timeout,
  input wire logic refused,
  input wire logic commandLatch,
  input wire logic addressLatch,
  input wire logic writeStrobeN,
  input wire logic chipEnableN,
  input wire logic [15:0] ioOut,
  input wire logic ioOe,
  input wire logic readyBusyN
);
  timeunit 1ns / 1ps;
  logic seenReset_r;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);
  // reset counts as sent once its byte is on the wire, even if it later times out
  always_ff @(posedge clk)
    seenReset_r <= reset ? 1'b0 : (seenReset_r | (commandLatch && ioOut[7:0] == 8'hff));
  property p_addrFrame;
    addressLatch |-> !chipEnableN && ioOe && !commandLatch;
  endproperty
  a_addrFrame: assert property (p_addrFrame) else $error("address cycle badly framed");
  property p_upperLow;
    addressLatch && ioOe |-> ioOut[15:8] == 8'h00;
  endproperty
  a_upperLow: assert property (p_upperLow) else $error("upper lines high in address");
  property p_spareCol;
    reqValid && reqReady && reqHasAddr && reqColumn[10] && reqColumn[9:5] != 5'h00 |=> refused;
  endproperty
  a_spareCol: assert property (p_spareCol) else $error("bad column not refused");
  property p_dataWait;
    $rose(writeStrobeN) && addressLatch |=> !dataGo [*8] ##1 !dataGo;
  endproperty
  a_dataWait: assert property (p_dataWait) else $error("data start too early");
  property p_busyWindow;
    $rose(writeStrobeN) |=> (!$rose(commandLatch)) [*8];
  endproperty
  a_busyWindow: assert property (p_busyWindow) else $error("command inside busy window");
  property p_cmdReady;
    $rose(commandLatch) |-> readyBusyN;
  endproperty
  a_cmdReady: assert property (p_cmdReady) else $error("command while busy");
  property p_doneReady;
    done |-> readyBusyN;
  endproperty
  a_doneReady: assert property (p_doneReady) else $error("done while device busy");
  property p_timeoutBusy;
    timeout |-> !readyBusyN;
  endproperty
  a_timeoutBusy: assert property (p_timeoutBusy) else $error("timeout while ready");
  property p_firstReset;
    reqValid && reqReady && reqCmd != 8'hff && !seenReset_r |=> refused;
  endproperty
  a_firstReset: assert property (p_firstReset) else $error("command before reset taken");
  property p_refuseCause;
    refused |-> $past(reqValid && reqReady);
  endproperty
  a_refuseCause: assert property (p_refuseCause) else $error("refused without request");
endmodule
`default_nettype wire

/* dv/nac_flash_model.sv */
// Purpose: behavioural flash die answering with ready/busy
// Assumes: strobes sampled on the host clock
// Notes: busy lengths scaled down to keep runs short
`default_nettype none
module nac_flash_model (
  input wire logic clk,
  input wire logic commandLatch,
  input wire logic addressLatch,
  input wire logic writeStrobeN,
  input wire logic [15:0] ioOut,
  input wire logic slowMode,
  output logic readyBusyN
);
  timeunit 1ns / 1ps;
  logic weQ = 1'b1;
  logic armed = 1'b0;
  logic everReset = 1'b0;
  logic [7:0] op = 8'h00;
  int dly = 0;
  int cnt = 0;
  initial readyBusyN = 1'b1;
  always @(posedge clk)
  begin
    weQ <= writeStrobeN;
    if (writeStrobeN && !weQ && commandLatch)
    begin
      op <= ioOut[7:0];
      armed <= ioOut[7:0] inside {8'hff, 8'h30, 8'h10};
    end
    if (armed && !commandLatch && !addressLatch && writeStrobeN && weQ)
    begin
      armed <= 1'b0;
      dly <= 3; // busy shows well inside the window
      // first reset long, later ones short; slow mode overruns the 200-cycle bench limits and the 500-cycle reset limit, not the read limit
      cnt <= slowMode ? 1000 : (op == 8'hff) ? (everReset ? 20 : 150) : (op == 8'h30) ? 40 : 100;
    end
    if (dly > 0)
    begin
      dly <= dly - 1;
      if (dly == 1)
        readyBusyN <= 1'b0;
    end
    else if (cnt > 0)
    begin
      cnt <= cnt - 1;
      if (cnt == 1)
      begin
        readyBusyN <= 1'b1;
        everReset <= everReset | (op == 8'hff);
      end
    end
  end
endmodule
`default_nettype wire

/* dv/nac_host_tb_top.sv */
// Purpose: directed bench for the host sequencer
// Assumes: first reset, erase and program limits shrunk to 200 cycles
// Notes: wire bytes captured on each rising write strobe
`default_nettype none
module nac_host_tb_top;
  timeunit 1ns / 1ps;
  logic clk = 1'b0, reset = 1'b1, reqValid = 1'b0, reqHasAddr = 1'b0, reqWaitBusy = 1'b0;
  logic reqLastCache = 1'b0, slowMode = 1'b0, weQ = 1'b1;
  logic [7:0] reqCmd = 8'h00;
  logic [2:0] reqBusyKind = 3'h0;
  logic [10:0] reqColumn = 11'h000;
  logic [5:0] reqPage = 6'h00;
  logic [16:0] reqBlock = 17'h00000;
  logic reqReady, dataGo, done, timeout, refused, commandLatch, addressLatch;
  logic writeStrobeN, read_strobe_n, chipEnableN, ioOe, readyBusyN, gotGo;
  logic [15:0] ioOut;
  logic [1:0] res;
  logic [17:0] cap[$];
  int n_mismatch = 0;
  int tests_run = 0;
  nac_host #(.FIRST_RESET_LIMIT(200), .ERASE_LIMIT(200), .PROGRAM_LIMIT(200),
    .LAST_PAGE_LIMIT(200)) dut (.clk, .reset, .reqValid, .reqReady, .reqCmd, .reqHasAddr,
    .reqWaitBusy, .reqBusyKind, .reqLastCache, .reqColumn, .reqPage, .reqBlock, .dataGo,
    .done, .timeout, .refused, .commandLatch, .addressLatch, .writeStrobeN,
    .read_strobe_n(), .chipEnableN, .ioOut, .ioOe, .readyBusyN);
  nac_flash_model flash (.clk, .commandLatch, .addressLatch, .writeStrobeN, .ioOut,
    .slowMode, .readyBusyN);
  always #5 clk = ~clk;
  always @(posedge clk)
  begin
    weQ <= writeStrobeN;
    if (writeStrobeN === 1'b1 && weQ === 1'b0)
      cap.push_back({commandLatch, addressLatch, ioOut});
  end
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input string what, input logic [17:0] got, input logic [17:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  // request fields held until the answer, valid for one cycle only; the 3000 bound cuts a hang
  task automatic req(input logic [7:0] cmd, input logic addr, input logic wt,
    input logic [2:0] kind, input logic [10:0] col, input logic [5:0] pg, input logic [16:0] blk);
    cap.delete();
    gotGo = 1'b0;
    res = 2'd3;
    @(posedge clk);
    #1;
    {reqCmd, reqHasAddr, reqWaitBusy, reqBusyKind, reqColumn, reqPage, reqBlock} =
      {cmd, addr, wt, kind, col, pg, blk};
    reqValid = 1'b1;
    @(posedge clk);
    #1;
    reqValid = 1'b0;
    // refused stands only in the cycle right after acceptance, so look before waiting
    for (int n = 0; n < 3000 && res == 2'd3; n++)
    begin
      gotGo = gotGo | (dataGo === 1'b1);
      res = (done === 1'b1) ? 2'd0 : (refused === 1'b1) ? 2'd1 : (timeout === 1'b1) ? 2'd2 : 2'd3;
      if (res == 2'd3)
      begin
        @(posedge clk);
        #1;
      end
    end
    if (res == 2'd3)
    begin
      n_mismatch++;
      tally_and_finish();
    end
  endtask
  task automatic chk_addr(input logic [7:0] cmd, input logic [10:0] col, input logic [5:0] pg,
    input logic [16:0] blk);
    logic [17:0] exp [6] = '{{10'h200, cmd}, {10'h100, col[7:0]}, {15'h2000, col[10:8]},
      {10'h100, blk[7:6], pg}, {10'h100, blk[15:8]}, {17'h08000, blk[16]}};
    chk("strobe count", 18'(cap.size()), 18'd6);
    for (int i = 0; i < 6 && i < cap.size(); i++)
      chk("wire byte", cap[i], exp[i]);
  endtask
  task automatic t_startup();
    req(8'h30, 1'b1, 1'b1, 3'h1, 11'h000, 6'h00, 17'h00000);
    chk("early read", 18'(res), 18'd1);
    req(8'hff, 1'b0, 1'b1, 3'h0, 11'h000, 6'h00, 17'h00000);
    chk("first reset", 18'(res), 18'd0);
    chk("reset byte", cap[0], 18'h200ff);
    req(8'hff, 1'b0, 1'b1, 3'h0, 11'h000, 6'h00, 17'h00000);
    chk("later reset", 18'(res), 18'd0);
  endtask
  // block values mix ones and zeros in every wire byte they reach
  task automatic t_reads();
    req(8'h30, 1'b1, 1'b1, 3'h1, 11'h0ff, 6'h2a, 17'h1fc05);
    chk("read a", 18'(res), 18'd0);
    chk_addr(8'h30, 11'h0ff, 6'h2a, 17'h1fc05);
    req(8'h30, 1'b1, 1'b1, 3'h1, 11'h400, 6'h15, 17'h003fa);
    chk("read spare", 18'(res), 18'd0);
    chk_addr(8'h30, 11'h400, 6'h15, 17'h003fa);
    req(8'h30, 1'b1, 1'b1, 3'h1, 11'h420, 6'h15, 17'h003fa);
    chk("bad column", 18'(res), 18'd1);
  endtask
  task automatic t_nowait();
    req(8'h80, 1'b1, 1'b0, 3'h2, 11'h010, 6'h01, 17'h00002);
    chk("setup done", 18'(res), 18'd0);
    chk("data go", 18'(gotGo), 18'd1);
    chk_addr(8'h80, 11'h010, 6'h01, 17'h00002);
  endtask
  task automatic t_partial();
    for (int i = 0; i < 5; i++)
    begin
      req(8'h10, 1'b1, 1'b1, 3'h2, 11'h000, 6'h05, 17'h00007);
      chk("partial program", 18'(res), (i < 4) ? 18'd0 : 18'd1);
    end
  endtask
  task automatic t_slow();
    slowMode = 1'b1;
    req(8'h10, 1'b1, 1'b1, 3'h2, 11'h000, 6'h09, 17'h00007);
    chk("overrun", 18'(res), 18'd2);
  endtask
  initial
  begin
    repeat (2) @(posedge clk);
    #1;
    reset = 1'b0;
    t_startup();
    t_reads();
    t_nowait();
    t_partial();
    t_slow();
    tally_and_finish();
  end
endmodule
bind nac_host nac_host_asserts u_chk (.clk, .reset, .reqValid, .reqReady, .reqCmd, .reqHasAddr,
  .reqColumn, .dataGo, .done, .timeout, .refused, .commandLatch, .addressLatch, .writeStrobeN,
  .chipEnableN, .ioOut, .ioOe, .readyBusyN);
`default_nettype wire
